//--- design/pemux_pkg.sv
package pemux_pkg;

  // ==========================================================
  // Pin count and package options
  // ==========================================================
  localparam int NUM_PINS = 5;
  localparam int PKG_PINS_SMALL = 64;
  localparam int PKG_PINS_LARGE = 80;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_LATCH = 12'h000;
  localparam logic [11:0] OFF_DIR = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_PIN = 12'h00c;
  localparam logic [11:0] OFF_OWNER = 12'h010;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int CTRL_PMP_EN = 0;
  localparam int CTRL_PMP_PLACE = 1;
  localparam int CTRL_PWM_PLACE = 2;
  localparam int CTRL_REF_CLOCK_OUT_EN = 3;
  localparam int CTRL_PMP_MASTER = 4;
  localparam int CTRL_PWM_EN_LSB = 5;
  localparam int CTRL_TRI_LSB = 10;
  localparam int CTRL_W = 15;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [4:0] DIR_RST = 5'h1f;
  localparam logic [14:0] CTRL_RST = 15'h0006;

  // ==========================================================
  // Pin positions of fixed functions
  // ==========================================================
  localparam int PIN_RD = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_BE = 2;
  localparam int PIN_A13 = 3;
  localparam int PIN_A12 = 4;
  localparam int PIN_REF_CLOCK_OUT = 3;
  localparam int STROBE_PINS = 3;

  // ==========================================================
  // Pin owner, one-hot
  // ==========================================================
  typedef enum logic [4:0] {
    OWN_LATCH = 5'h01,
    OWN_PMP = 5'h02,
    OWN_REF_CLOCK_OUT = 5'h04,
    OWN_PWM = 5'h08,
    OWN_EMI = 5'h10
  } pemux_owner_type;

endpackage

//--- design/pemux_pin_cell.sv
// ============================================================
// One pin: fixed priority selection of data and direction
// ============================================================
module pemux_pin_cell (
  input wire logic emi_active,
  input wire logic emi_drive,
  input wire logic emi_data,
  input wire logic pwm_sel,
  input wire logic pwm_data,
  input wire logic pwm_shutdown,
  input wire logic pwm_tri_sel,
  input wire logic ref_clock_out_sel,
  input wire logic ref_clock_out_data,
  input wire logic pmp_sel,
  input wire logic pmp_drive,
  input wire logic pmp_data,
  input wire logic latch_bit,
  input wire logic pin_direction_bit,
  output logic pin_out,
  output logic pin_oe,
  output pemux_pkg::pemux_owner_type owner
);

  // Direction comes from the owning function, not the direction bit
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    owner = pemux_pkg::OWN_LATCH;
    if (emi_active) begin
      owner = pemux_pkg::OWN_EMI;
      pin_out = emi_data;
      pin_oe = emi_drive;
    end else if (pwm_sel && !pin_direction_bit) begin
      owner = pemux_pkg::OWN_PWM;
      pin_out = pwm_data;
      // Shutdown may float the stage rather than hold a level
      pin_oe = !(pwm_shutdown && pwm_tri_sel);
    end else if (ref_clock_out_sel) begin
      owner = pemux_pkg::OWN_REF_CLOCK_OUT;
      pin_out = ref_clock_out_data;
      pin_oe = 1'b1;
    end else if (pmp_sel) begin
      owner = pemux_pkg::OWN_PMP;
      pin_out = pmp_data;
      pin_oe = pmp_drive;
    end else begin
      pin_out = latch_bit;
      pin_oe = !pin_direction_bit;
    end
  end

endmodule

//--- design/pemux_pmp_route.sv
// ============================================================
// Parallel port function placement onto pins 0 to 4
// ============================================================
module pemux_pmp_route (
  input wire logic pmp_en,
  input wire logic par_port_placement_cfg,
  input wire logic par_port_master,
  input wire logic par_port_read_strobe,
  input wire logic par_port_write_strobe,
  input wire logic par_port_byte_enable,
  input wire logic par_port_addr_b13,
  input wire logic par_port_addr_b12,
  output logic [4:0] pmp_sel,
  output logic [4:0] pmp_drive,
  output logic [4:0] pmp_data
);

  logic strobes_here;

  // Strobes and byte enable only sit here in the default placement
  assign strobes_here = pmp_en && par_port_placement_cfg;

  // Per-pin selection, direction and data
  always_comb begin
    pmp_sel = 5'h00;
    pmp_drive = 5'h00;
    pmp_data = 5'h00;
    pmp_sel[pemux_pkg::PIN_RD] = strobes_here;
    pmp_drive[pemux_pkg::PIN_RD] = par_port_master;
    pmp_data[pemux_pkg::PIN_RD] = par_port_read_strobe;
    pmp_sel[pemux_pkg::PIN_WR] = strobes_here;
    pmp_drive[pemux_pkg::PIN_WR] = par_port_master;
    pmp_data[pemux_pkg::PIN_WR] = par_port_write_strobe;
    pmp_sel[pemux_pkg::PIN_BE] = strobes_here;
    pmp_drive[pemux_pkg::PIN_BE] = 1'b1;
    pmp_data[pemux_pkg::PIN_BE] = par_port_byte_enable;
    pmp_sel[pemux_pkg::PIN_A13] = pmp_en;
    pmp_drive[pemux_pkg::PIN_A13] = 1'b1;
    pmp_data[pemux_pkg::PIN_A13] = par_port_addr_b13;
    pmp_sel[pemux_pkg::PIN_A12] = pmp_en;
    pmp_drive[pemux_pkg::PIN_A12] = 1'b1;
    pmp_data[pemux_pkg::PIN_A12] = par_port_addr_b12;
  end

endmodule

//--- design/pemux_port_e_low.sv
// What this block does
// - Unowned pin acts as plain port bit
// - Memory bus carries address/data 8..12 here
// - Memory bus overrides every other function
// - Owning function sets pin direction itself
// - Pin 0 is parallel read strobe
// - Pin 1 is parallel write strobe
// - Pin 2 outputs parallel byte enable
// - Pins 3, 4 output parallel address 13, 12
// - Strobes on pins 0-2 need placement bit
// - PWM two D, C, B on pins 0-2
// - PWM outputs may float during shutdown
// - PWM three C, B need placement, 80-pin
// - Pin 3 may output reference clock
module pemux_port_e_low #(
  parameter int PKG_PINS = pemux_pkg::PKG_PINS_LARGE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] port_e_pin_input,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  input wire logic ext_bus_active,
  input wire logic ext_bus_drive,
  input wire logic [4:0] ext_bus_addr_data_out,
  output logic [4:0] ext_bus_addr_data_in,
  input wire logic par_port_master,
  input wire logic par_port_read_strobe,
  input wire logic par_port_write_strobe,
  input wire logic par_port_byte_enable,
  input wire logic par_port_addr_b13,
  input wire logic par_port_addr_b12,
  output logic par_port_read_in,
  output logic par_port_write_in,
  input wire logic pwm_two_channel_d,
  input wire logic pwm_two_channel_c,
  input wire logic pwm_two_channel_b,
  input wire logic pwm_two_shutdown,
  input wire logic pwm_three_channel_c,
  input wire logic pwm_three_channel_b,
  input wire logic pwm_three_shutdown,
  input wire logic ref_clock_out
);

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (PKG_PINS != pemux_pkg::PKG_PINS_SMALL &&
      PKG_PINS != pemux_pkg::PKG_PINS_LARGE) begin : g_bad_pkg
    $error("PKG_PINS must be 64 or 80");
  end

  // Memory bus and unit three placement exist on the larger package
  localparam logic IS_LARGE = (PKG_PINS == pemux_pkg::PKG_PINS_LARGE);

  // ==========================================================
  // Declarations
  // ==========================================================
  // Software-visible state
  logic [4:0] latch_reg;
  logic [4:0] pin_direction_bit_reg;
  logic [14:0] ctrl_reg;
  logic [4:0] pin_in_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Registered outputs and returns
  logic [4:0] pin_out_reg;
  logic [4:0] pin_oe_reg;
  logic [4:0] ext_in_reg;
  logic rd_in_reg;
  logic wr_in_reg;
  logic [24:0] owner_reg;
  // Next values and bus decode
  logic [4:0] pin_out_next;
  logic [4:0] pin_oe_next;
  logic [24:0] owner_next;
  logic [31:0] rdata_next;
  logic access;
  logic commit;
  // Per-function select, data and drive
  logic emi_active;
  logic par_port_placement_cfg;
  logic pwm_output_placement_cfg;
  logic [4:0] pwm_en;
  logic [4:0] pwm_tri;
  logic [4:0] pwm_sel;
  logic [4:0] pwm_data;
  logic [4:0] pwm_shut;
  logic [4:0] ref_clock_out_sel;
  logic [4:0] ref_clock_out_data;
  logic [4:0] pmp_sel;
  logic [4:0] pmp_drive;
  logic [4:0] pmp_data;
  pemux_pkg::pemux_owner_type owner [pemux_pkg::NUM_PINS];

  // ==========================================================
  // Address decode
  // ==========================================================
  // Whole-offset match; no aliases, so stray writes stay harmless
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Anything else answers with an error
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, pemux_pkg::OFF_LATCH) || hit(a, pemux_pkg::OFF_DIR) ||
             hit(a, pemux_pkg::OFF_CTRL) || hit(a, pemux_pkg::OFF_PIN) ||
             hit(a, pemux_pkg::OFF_OWNER);
  endfunction

  // ==========================================================
  // APB handshake: one wait state, then pready for one cycle
  // ==========================================================
  assign access = psel && penable && !pready_reg;
  assign commit = psel && penable && pready_reg;

  // Read data and error are captured one edge before commit
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit(paddr, pemux_pkg::OFF_LATCH)) begin
      rdata_next[4:0] = latch_reg;
    end else if (hit(paddr, pemux_pkg::OFF_DIR)) begin
      rdata_next[4:0] = pin_direction_bit_reg;
    end else if (hit(paddr, pemux_pkg::OFF_CTRL)) begin
      rdata_next[14:0] = ctrl_reg;
    end else if (hit(paddr, pemux_pkg::OFF_PIN)) begin
      rdata_next[4:0] = pin_in_reg;
    end else if (hit(paddr, pemux_pkg::OFF_OWNER)) begin
      rdata_next[24:0] = owner_reg;
    end
  end

  // pready is a one-cycle pulse; pslverr rides with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped(paddr);
      if (access && !pwrite) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  // ==========================================================
  // Software registers; writes land at the completing edge
  // ==========================================================
  // Writes to read-only offsets are dropped without an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= pemux_pkg::LATCH_RST;
      pin_direction_bit_reg <= pemux_pkg::DIR_RST;
      ctrl_reg <= pemux_pkg::CTRL_RST;
    end else if (commit && pwrite) begin
      if (hit(paddr, pemux_pkg::OFF_LATCH)) begin
        latch_reg <= pwdata[4:0];
      end
      if (hit(paddr, pemux_pkg::OFF_DIR)) begin
        pin_direction_bit_reg <= pwdata[4:0];
      end
      if (hit(paddr, pemux_pkg::OFF_CTRL)) begin
        ctrl_reg <= pwdata[14:0];
      end
    end
  end

  // ==========================================================
  // Function selection per pin
  // ==========================================================
  // Memory bus exists only on the larger package
  assign emi_active = IS_LARGE && ext_bus_active;
  assign par_port_placement_cfg = ctrl_reg[pemux_pkg::CTRL_PMP_PLACE];
  assign pwm_output_placement_cfg = ctrl_reg[pemux_pkg::CTRL_PWM_PLACE];
  assign pwm_en = ctrl_reg[pemux_pkg::CTRL_PWM_EN_LSB +: 5];
  assign pwm_tri = ctrl_reg[pemux_pkg::CTRL_TRI_LSB +: 5];

  // PWM two always lives on pins 0-2; unit three needs its placement
  assign pwm_sel[2:0] = pwm_en[2:0];
  assign pwm_sel[4:3] = pwm_en[4:3] &
      {2{IS_LARGE && pwm_output_placement_cfg}};
  assign pwm_data = {pwm_three_channel_b, pwm_three_channel_c,
                     pwm_two_channel_b, pwm_two_channel_c,
                     pwm_two_channel_d};
  assign pwm_shut = {{2{pwm_three_shutdown}}, {3{pwm_two_shutdown}}};

  // Reference clock only reaches pin 3
  always_comb begin
    ref_clock_out_sel = 5'h00;
    ref_clock_out_data = 5'h00;
    ref_clock_out_sel[pemux_pkg::PIN_REF_CLOCK_OUT] =
        ctrl_reg[pemux_pkg::CTRL_REF_CLOCK_OUT_EN];
    ref_clock_out_data[pemux_pkg::PIN_REF_CLOCK_OUT] = ref_clock_out;
  end

  // Address pins follow the enable alone; strobes need placement
  pemux_pmp_route u_pmp_route (
    .pmp_en(ctrl_reg[pemux_pkg::CTRL_PMP_EN]),
    .par_port_placement_cfg(par_port_placement_cfg),
    .par_port_master(par_port_master),
    .par_port_read_strobe(par_port_read_strobe),
    .par_port_write_strobe(par_port_write_strobe),
    .par_port_byte_enable(par_port_byte_enable),
    .par_port_addr_b13(par_port_addr_b13),
    .par_port_addr_b12(par_port_addr_b12),
    .pmp_sel(pmp_sel),
    .pmp_drive(pmp_drive),
    .pmp_data(pmp_data)
  );

  // ==========================================================
  // Pin cells
  // ==========================================================
  // One cell per pin; all cells share the same priority order
  for (genvar i = 0; i < pemux_pkg::NUM_PINS; i++) begin : g_pin
    pemux_pin_cell u_cell (
      .emi_active(emi_active),
      .emi_drive(ext_bus_drive),
      .emi_data(ext_bus_addr_data_out[i]),
      .pwm_sel(pwm_sel[i]),
      .pwm_data(pwm_data[i]),
      .pwm_shutdown(pwm_shut[i]),
      .pwm_tri_sel(pwm_tri[i]),
      .ref_clock_out_sel(ref_clock_out_sel[i]),
      .ref_clock_out_data(ref_clock_out_data[i]),
      .pmp_sel(pmp_sel[i]),
      .pmp_drive(pmp_drive[i]),
      .pmp_data(pmp_data[i]),
      .latch_bit(latch_reg[i]),
      .pin_direction_bit(pin_direction_bit_reg[i]),
      .pin_out(pin_out_next[i]),
      .pin_oe(pin_oe_next[i]),
      .owner(owner[i])
    );
    // Five bits per pin in the owner status word
    assign owner_next[5*i +: 5] = owner[i];
  end

  // ==========================================================
  // Registered pin drive; costs one cycle of latency on all paths
  // ==========================================================
  // Reset clears every enable, so only an active memory bus can drive a pin before software
  // Latency traded for glitch-free pins while the mux settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 5'h00;
      pin_oe_reg <= 5'h00;
      owner_reg <= 25'h0000000;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      owner_reg <= owner_next;
    end
  end

  // ==========================================================
  // Inputs back to software and peripherals
  // ==========================================================
  // Pins are already synchronous, so one stage is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_in_reg <= 5'h00;
      ext_in_reg <= 5'h00;
      rd_in_reg <= 1'b0;
      wr_in_reg <= 1'b0;
    end else begin
      pin_in_reg <= port_e_pin_input;
      // Idle bus reads zero so stale pin data never leaks
      ext_in_reg <= emi_active ? port_e_pin_input : 5'h00;
      // Strobe inputs only count while the port is a slave
      rd_in_reg <= (owner[pemux_pkg::PIN_RD] == pemux_pkg::OWN_PMP) &&
                   !par_port_master &&
                   port_e_pin_input[pemux_pkg::PIN_RD];
      wr_in_reg <= (owner[pemux_pkg::PIN_WR] == pemux_pkg::OWN_PMP) &&
                   !par_port_master &&
                   port_e_pin_input[pemux_pkg::PIN_WR];
    end
  end

  // Every output comes straight from a flip-flop
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign ext_bus_addr_data_in = ext_in_reg;
  assign par_port_read_in = rd_in_reg;
  assign par_port_write_in = wr_in_reg;

endmodule

//--- dv/pemux_pin_partner.sv
// ==========================================================
// Far side of the five pins
// ==========================================================
module pemux_pin_partner (
  input wire logic pclk,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] drv_en,
  input wire logic [4:0] drv_val,
  output logic [4:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last_reg = 5'h00;
  // Undriven pin drifts each cycle, so a stale value never looks valid
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pin_level[i] = drv_val[i];
      end else begin
        pin_level[i] = ~last_reg[i];
      end
    end
  end
  // Last wire level
  always_ff @(posedge pclk) begin
    last_reg <= pin_level;
  end
endmodule

//--- dv/pemux_port_e_low_props.sv
// ==========================================================
// Pin mux checker
// ==========================================================
module pemux_port_e_low_props #(
  parameter int PKG_PINS = 80
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] port_e_pin_input,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic ext_bus_active,
  input wire logic ext_bus_drive,
  input wire logic [4:0] ext_bus_addr_data_out,
  input wire logic [4:0] ext_bus_addr_data_in,
  input wire logic par_port_master,
  input wire logic par_port_read_in,
  input wire logic par_port_write_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam bit EMI_OK = (PKG_PINS == 80);
  // Memory bus takes all five pins
  a_emi_owns_oe: assert property (
    EMI_OK && ext_bus_active |=> pin_oe == {5{$past(ext_bus_drive)}})
    else $error("memory bus direction not on all pins");
  a_emi_data_out: assert property (
    EMI_OK && ext_bus_active && ext_bus_drive
    |=> pin_out == $past(ext_bus_addr_data_out))
    else $error("memory bus data not on pins");
  a_emi_data_in: assert property (
    EMI_OK && ext_bus_active
    |=> ext_bus_addr_data_in == $past(port_e_pin_input))
    else $error("memory bus read data wrong");
  a_emi_idle_in: assert property (
    !ext_bus_active |=> ext_bus_addr_data_in == 5'h00)
    else $error("memory bus input not quiet");
  // Strobe inputs only when not master
  a_master_no_in: assert property (
    par_port_master |=> !par_port_read_in && !par_port_write_in)
    else $error("strobe input seen in master mode");
  a_read_in_pin: assert property (
    par_port_read_in |-> $past(port_e_pin_input[0]))
    else $error("read strobe input not from pin 0");
  a_write_in_pin: assert property (
    par_port_write_in |-> $past(port_e_pin_input[1]))
    else $error("write strobe input not from pin 1");
  a_reset_inputs: assert property (
    $rose(presetn) && !ext_bus_active |-> pin_oe == 5'h00 ##1 pin_oe == 5'h00)
    else $error("pin driven after reset");
  c_emi_write: cover property (ext_bus_active && ext_bus_drive);
  c_read_in: cover property (par_port_read_in);
  c_all_out: cover property (pin_oe == 5'h1f && !ext_bus_active);
endmodule

bind pemux_port_e_low pemux_port_e_low_props #(.PKG_PINS(PKG_PINS)) u_props (
  .pclk, .presetn, .port_e_pin_input, .pin_out, .pin_oe, .ext_bus_active,
  .ext_bus_drive, .ext_bus_addr_data_out, .ext_bus_addr_data_in,
  .par_port_master, .par_port_read_in, .par_port_write_in
);

//--- dv/test_port_e_low_pin_function_mux.sv
// ==========================================================
// Pin mux bench
// ==========================================================
module test_port_e_low_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic ext_bus_active, ext_bus_drive, par_port_master, ref_clock_out;
  logic par_port_read_strobe, par_port_write_strobe, par_port_byte_enable;
  logic par_port_addr_b13, par_port_addr_b12;
  logic par_port_read_in, par_port_write_in, pwm_two_shutdown;
  logic pwm_two_channel_d, pwm_two_channel_c, pwm_two_channel_b;
  logic pwm_three_channel_c, pwm_three_channel_b, pwm_three_shutdown;
  logic [4:0] port_e_pin_input, pin_out, pin_oe, drv_en, drv_val;
  logic [4:0] ext_bus_addr_data_out, ext_bus_addr_data_in;
  int error_cnt = 0;
  int cmp_count = 0;

  pemux_port_e_low #(.PKG_PINS(80)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_e_pin_input, .pin_out, .pin_oe,
    .ext_bus_active, .ext_bus_drive, .ext_bus_addr_data_out,
    .ext_bus_addr_data_in, .par_port_master, .par_port_read_strobe,
    .par_port_write_strobe, .par_port_byte_enable, .par_port_addr_b13,
    .par_port_addr_b12, .par_port_read_in, .par_port_write_in,
    .pwm_two_channel_d, .pwm_two_channel_c, .pwm_two_channel_b,
    .pwm_two_shutdown, .pwm_three_channel_c, .pwm_three_channel_b,
    .pwm_three_shutdown, .ref_clock_out
  );
  pemux_pin_partner u_far (.pclk, .pin_out, .pin_oe, .drv_en, .drv_val,
    .pin_level(port_e_pin_input));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // A hung slave is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic pins(input logic [4:0] o, input logic [4:0] e);
    settle;
    chk(32'(pin_out), 32'(o));
    chk(32'(pin_oe), 32'(e));
  endtask

  task automatic set_pmp(input logic [4:0] v);
    {par_port_addr_b12, par_port_addr_b13, par_port_byte_enable,
      par_port_write_strobe, par_port_read_strobe} <= v;
  endtask

  task automatic set_pwm(input logic [4:0] v);
    {pwm_three_channel_b, pwm_three_channel_c, pwm_two_channel_b,
      pwm_two_channel_c, pwm_two_channel_d} <= v;
  endtask

  task automatic t_reset;
    chk(32'(pin_oe), 32'h0);
    rd(pemux_pkg::OFF_LATCH, 32'h0);
    rd(pemux_pkg::OFF_DIR, 32'h1f);
    rd(pemux_pkg::OFF_CTRL, 32'h6);
    rd(pemux_pkg::OFF_OWNER, 32'h00108421);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("reset test done");
  endtask

  task automatic t_latch;
    apb(1'b1, pemux_pkg::OFF_DIR, 32'h0);
    apb(1'b1, pemux_pkg::OFF_LATCH, 32'h15);
    pins(5'h15, 5'h1f);
    apb(1'b1, pemux_pkg::OFF_DIR, 32'h1f);
    drv_en <= 5'h1f;
    drv_val <= 5'h0a;
    settle;
    chk(32'(pin_oe), 32'h0);
    apb(1'b1, pemux_pkg::OFF_PIN, 32'h1f);
    rd(pemux_pkg::OFF_PIN, 32'h0a);
    $display("latch test done");
  endtask

  task automatic t_pmp;
    set_pmp(5'h0d);
    par_port_master <= 1'b1;
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h7);
    pins(5'h0d, 5'h1f);
    rd(pemux_pkg::OFF_OWNER, 32'h00210842);
    par_port_master <= 1'b0;
    drv_val <= 5'h01;
    settle;
    chk(32'(pin_oe), 32'h1c);
    chk(32'({par_port_write_in, par_port_read_in}), 32'h1);
    drv_val <= 5'h02;
    settle;
    chk(32'({par_port_write_in, par_port_read_in}), 32'h2);
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h5);
    settle;
    chk(32'(pin_oe), 32'h18);
    chk(32'(pin_out & 5'h18), 32'h08);
    $display("parallel port test done");
  endtask

  task automatic t_pwm;
    set_pmp(5'h12);
    set_pwm(5'h0d);
    par_port_master <= 1'b1;
    apb(1'b1, pemux_pkg::OFF_DIR, 32'h0);
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h3e7);
    pins(5'h0d, 5'h1f);
    rd(pemux_pkg::OFF_OWNER, 32'h00842108);
    pwm_two_shutdown <= 1'b1;
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h7fe7);
    pins(5'h0d, 5'h18);
    pwm_three_shutdown <= 1'b1;
    pins(5'h0d, 5'h00);
    pwm_two_shutdown <= 1'b0;
    pwm_three_shutdown <= 1'b0;
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h3e3);
    pins(5'h15, 5'h1f);
    apb(1'b1, pemux_pkg::OFF_DIR, 32'h1f);
    pins(5'h12, 5'h1f);
    $display("pwm test done");
  endtask

  task automatic t_ref_clock_out;
    ref_clock_out <= 1'b1;
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h9);
    settle;
    chk(32'(pin_out & 5'h08), 32'h08);
    chk(32'(pin_oe & 5'h08), 32'h08);
    ref_clock_out <= 1'b0;
    settle;
    chk(32'(pin_out & 5'h08), 32'h0);
    $display("reference clock test done");
  endtask

  task automatic t_emi;
    apb(1'b1, pemux_pkg::OFF_DIR, 32'h0);
    apb(1'b1, pemux_pkg::OFF_CTRL, 32'h3ef);
    ext_bus_addr_data_out <= 5'h13;
    ext_bus_active <= 1'b1;
    ext_bus_drive <= 1'b1;
    pins(5'h13, 5'h1f);
    rd(pemux_pkg::OFF_OWNER, 32'h01084210);
    ext_bus_drive <= 1'b0;
    drv_val <= 5'h0a;
    settle;
    chk(32'(pin_oe), 32'h0);
    chk(32'(ext_bus_addr_data_in), 32'h0a);
    ext_bus_active <= 1'b0;
    settle;
    chk(32'(ext_bus_addr_data_in), 32'h0);
    $display("memory bus test done");
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_bus_active, ext_bus_drive, ext_bus_addr_data_out} = '0;
    {par_port_master, ref_clock_out, drv_en, drv_val} = '0;
    {pwm_two_shutdown, pwm_three_shutdown} = '0;
    set_pmp(5'h0);
    set_pwm(5'h0);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_latch;
    t_pmp;
    t_pwm;
    t_ref_clock_out;
    t_emi;
    final_report;
  end

  // Watchdog, far beyond the 150 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
endmodule
